// [verilog/ibc_consts.svh]
// Constants of the two-wire bus protocol core
// Operation
// R1: SDA falling while SCL high is a start; we generate and detect it.
// R2: SDA rising while SCL high is a stop; we generate and detect it.
// R3: Only a master makes start or stop; the slave side never does.
// R4: Bus busy after a start; free only a bus-free time after stop.
// R5: Repeated start keeps the bus busy and acts as a normal start.
// R6: Sampled detection must look at SDA at least twice per SCL period.
// R7: Every byte is exactly eight bits; any number of bytes per transfer.
// R8: Each byte is followed by one acknowledge bit slot.
// R9: Bits move most significant first.
// R10: A slave may hold SCL low; master waits until it is released.
// R11: The master makes every clock pulse, including the ninth.
// R12: Transmitter releases SDA in the ack slot; acker holds it low.
// R13: High ack slot is a NACK; then only stop or repeated start. The core blocks other commands only after a NACK on a write.
// R14: A reading master NACKs the last byte it wants.
// R15: A receiver NACKs when unaddressed, busy or unable to take bytes.
// R16: Each master starts its low count on any SCL fall and holds SCL low.
// R17: Early master waits on low SCL; first to end high pulls SCL low.
// R18: A master starts a transfer only when the bus shows free.
// R19: Sending high but seeing low while SCL high loses arbitration.
// R20: After a loss stop driving and retry when the bus is free.
// R21: Losing in the address phase switches at once to slave operation.
// R22: Slow devices may stretch each low period; masters adapt.
// R23: High-speed mode stretches only between bytes, not within bits.
// R24: SDA stays stable while SCL high except at start and stop.
// R25: Lines are only pulled low or released: wired-AND.
// R26: Any start resets byte sequencing so the next byte is an address.
`ifndef IBC_CONSTS_SVH
`define IBC_CONSTS_SVH
`define IBC_CLK_NS    100
`define IBC_T_LOW_NS  4700
`define IBC_T_HIGH_NS 4000
`define IBC_T_BUF_NS  4700
`define IBC_T_SU_NS   4700
`define IBC_T_HD_NS   4000
`define IBC_T_DAT_NS  300
`define IBC_CYC(ns) (((ns) + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_LOW_CYC  8'(`IBC_CYC(`IBC_T_LOW_NS))
`define IBC_HIGH_CYC 8'(`IBC_CYC(`IBC_T_HIGH_NS))
`define IBC_BUF_CYC  8'(`IBC_CYC(`IBC_T_BUF_NS))
`define IBC_SU_CYC   8'(`IBC_CYC(`IBC_T_SU_NS))
`define IBC_HD_CYC   8'(`IBC_CYC(`IBC_T_HD_NS))
`define IBC_DAT_CYC  8'(`IBC_CYC(`IBC_T_DAT_NS))
`define IBC_ACK_BIT  4'h8
`define IBC_PRE_BIT  4'hF
`define IBC_FIFO_W   8
`define IBC_FIFO_D   8
`endif

// [verilog/ibc_pkg.sv]
// Types of the two-wire bus protocol core
package ibc_pkg;
    typedef enum logic [1:0] {
        IBC_CMD_START = 2'h0,
        IBC_CMD_WRITE = 2'h1,
        IBC_CMD_READ  = 2'h2,
        IBC_CMD_STOP  = 2'h3
    } ibc_cmd_t;
    typedef enum logic [2:0] {
        IBC_M_IDLE  = 3'h0,
        IBC_M_WFREE = 3'h1,
        IBC_M_HOLD  = 3'h2,
        IBC_M_LOW   = 3'h3,
        IBC_M_HIGH  = 3'h4
    } ibc_mstate_t;
    typedef enum logic [1:0] {
        IBC_ACT_BIT  = 2'h0,
        IBC_ACT_RS   = 2'h1,
        IBC_ACT_STOP = 2'h2
    } ibc_act_t;
endpackage

// [verilog/ibc_core.sv]
// Two-wire bus protocol engine with receive FIFO
`timescale 1ns/1ns
`include "ibc_consts.svh"

module ibc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0]   cnt_q;
    logic          push, pop;
    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // ibc_fifo

module ibc_core (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    input  wire logic [6:0]        own_addr,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire ibc_pkg::ibc_cmd_t cmd,
    input  wire logic [7:0]        cmd_data,
    input  wire logic              cmd_nack,
    output logic                   res_valid,
    output logic                   res_nack,
    output logic                   res_lost,
    output logic                   res_err,
    input  wire logic [7:0]        slv_tx_data,
    output logic                   slv_sel,
    output logic [7:0]             rx_data,
    output logic                   rx_valid,
    input  wire logic              rx_ready,
    output logic                   bus_busy
);
    import ibc_pkg::*;

    logic scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic busy_q, freeing_q;
    logic [7:0] buf_cnt_q;
    ibc_mstate_t m_state_q;
    ibc_act_t    m_act_q;
    logic [7:0]  m_cnt_q, m_sh_q;
    logic [3:0]  m_bit_q;
    logic        m_sda_q, m_scl_q, m_own_q, m_rd_q, m_nack_q;
    logic        m_after_nack_q, accept, arb_lost, push_ok;
    logic        rs_valid_q, rs_nack_q, rs_lost_q, rs_err_q;
    logic [3:0]  s_cnt_q;
    logic [7:0]  s_sh_q, s_tx_q;
    logic        s_addr_q, s_sel_q, s_rd_q, s_sda_q, s_go_q;
    logic        push_q, scl_oe_q, sda_oe_q, rdy_q;
    logic [7:0]  push_data_q;
    logic        fifo_ready;

    // Two stages before any logic; samples SDA eight times per bench SCL
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_s1, scl_s2, scl_p} <= 3'h7;
            {sda_s1, sda_s2, sda_p} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_p} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_p} <= {sda_i, sda_s1, sda_s2};
        end
    end
    assign scl_rise  = scl_s2 & ~scl_p;
    assign scl_fall  = ~scl_s2 & scl_p;
    assign start_det = scl_s2 & scl_p & sda_p & ~sda_s2;    // [R1] [R6]
    assign stop_det  = scl_s2 & scl_p & ~sda_p & sda_s2;    // [R2] [R6]

    // Bus free only after the bus-free time with no new start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q    <= 1'b0;
            freeing_q <= 1'b0;
            buf_cnt_q <= 8'h00;
        end else if (start_det) begin
            busy_q    <= 1'b1;                              // [R4] [R5]
            freeing_q <= 1'b0;
        end else if (stop_det) begin
            freeing_q <= 1'b1;
            buf_cnt_q <= 8'h00;
        end else if (freeing_q) begin
            buf_cnt_q <= buf_cnt_q + 8'h01;
            if (buf_cnt_q == `IBC_BUF_CYC - 8'h01) begin
                busy_q    <= 1'b0;                          // [R4]
                freeing_q <= 1'b0;
            end
        end
    end

    assign accept = cmd_valid & rdy_q;
    // Sending a one but reading a zero while SCL is high
    assign arb_lost = (m_state_q == IBC_M_HIGH) && (m_act_q == IBC_ACT_BIT)
                      && !m_rd_q && (m_bit_q < `IBC_ACK_BIT) && m_sh_q[7]
                      && scl_s2 && !sda_s2;                 // [R19]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_state_q <= IBC_M_IDLE;
            m_act_q   <= IBC_ACT_BIT;
            m_cnt_q   <= 8'h00;
            m_sh_q    <= 8'h00;
            m_bit_q   <= 4'h0;
            m_sda_q   <= 1'b0;
            m_scl_q   <= 1'b0;
            m_own_q   <= 1'b0;
            m_rd_q    <= 1'b0;
            m_nack_q  <= 1'b0;
            m_after_nack_q <= 1'b0;
            rs_valid_q <= 1'b0;
            rs_nack_q  <= 1'b0;
            rs_lost_q  <= 1'b0;
            rs_err_q   <= 1'b0;
        end else begin
            rs_valid_q <= 1'b0;
            rs_lost_q  <= 1'b0;
            rs_err_q   <= 1'b0;
            m_cnt_q    <= m_cnt_q + 8'h01;
            case (m_state_q)
                IBC_M_IDLE: begin
                    if (accept) begin
                        m_cnt_q <= 8'h00;
                        case (cmd)
                            IBC_CMD_START: begin
                                m_act_q <= IBC_ACT_RS;
                                m_state_q <= m_own_q ? IBC_M_LOW
                                                     : IBC_M_WFREE;
                            end
                            IBC_CMD_STOP: begin
                                m_act_q   <= IBC_ACT_STOP;
                                m_state_q <= IBC_M_LOW;
                            end
                            default: begin
                                m_act_q   <= IBC_ACT_BIT;
                                m_sh_q    <= cmd_data;
                                m_rd_q    <= (cmd == IBC_CMD_READ);
                                m_nack_q  <= cmd_nack;      // [R14]
                                m_bit_q   <= 4'h0;
                                m_state_q <= IBC_M_LOW;
                            end
                        endcase
                        // After a NACK on a write only stop or repeated start go
                        if (!m_own_q && cmd != IBC_CMD_START
                            || m_after_nack_q && (cmd == IBC_CMD_WRITE
                            || cmd == IBC_CMD_READ)) begin   // [R13]
                            m_state_q  <= IBC_M_IDLE;
                            rs_valid_q <= 1'b1;
                            rs_err_q   <= 1'b1;
                        end
                    end
                end
                IBC_M_WFREE: begin
                    m_cnt_q <= 8'h00;
                    if (!busy_q) begin                      // [R18]
                        m_sda_q   <= 1'b1;                  // [R1] [R3]
                        m_own_q   <= 1'b1;
                        m_state_q <= IBC_M_HOLD;
                    end
                end
                IBC_M_HOLD: begin
                    if (m_cnt_q == `IBC_HD_CYC - 8'h01) begin
                        m_scl_q    <= 1'b1;
                        m_cnt_q    <= 8'h00;
                        m_after_nack_q <= 1'b0;
                        rs_valid_q <= 1'b1;
                        m_state_q  <= IBC_M_IDLE;
                    end
                end
                IBC_M_LOW: begin
                    m_scl_q <= 1'b1;                        // [R11] [R16]
                    // Data moves only well inside the low phase
                    if (m_cnt_q == `IBC_DAT_CYC) begin      // [R24]
                        case (m_act_q)
                            IBC_ACT_RS:   m_sda_q <= 1'b0;
                            IBC_ACT_STOP: m_sda_q <= 1'b1;
                            default: begin
                                if (m_bit_q == `IBC_ACK_BIT) begin
                                    m_sda_q <= m_rd_q & ~m_nack_q; // [R12]
                                end else begin
                                    m_sda_q <= ~m_rd_q & ~m_sh_q[7]; // [R9]
                                end
                            end
                        endcase
                    end
                    if (m_cnt_q == `IBC_LOW_CYC - 8'h01) begin
                        m_scl_q   <= 1'b0;
                        m_cnt_q   <= 8'h00;
                        m_state_q <= IBC_M_HIGH;
                    end
                end
                IBC_M_HIGH: begin
                    if (!scl_s2 && m_cnt_q == 8'h00) begin
                        m_cnt_q <= 8'h00;                   // [R10] [R22]
                    end else if (!scl_s2) begin
                        // Another master ended its high first
                        m_scl_q   <= 1'b1;                  // [R16] [R17]
                        m_cnt_q   <= 8'h00;
                        m_state_q <= IBC_M_LOW;
                    end else if (arb_lost) begin
                        m_sda_q   <= 1'b0;                  // [R19] [R20]
                        m_own_q   <= 1'b0;                  // [R21]
                        rs_valid_q <= 1'b1;
                        rs_lost_q  <= 1'b1;
                        m_state_q <= IBC_M_IDLE;
                    end else begin
                        if (m_act_q == IBC_ACT_RS
                            && m_cnt_q == `IBC_SU_CYC - 8'h01) begin
                            m_sda_q   <= 1'b1;              // [R5]
                            m_cnt_q   <= 8'h00;
                            m_state_q <= IBC_M_HOLD;
                        end
                        if (m_act_q == IBC_ACT_STOP
                            && m_cnt_q == `IBC_SU_CYC - 8'h01) begin
                            m_sda_q    <= 1'b0;             // [R2] [R3]
                            m_own_q    <= 1'b0;
                            rs_valid_q <= 1'b1;
                            m_state_q  <= IBC_M_IDLE;
                        end
                        if (m_act_q == IBC_ACT_BIT
                            && m_cnt_q == `IBC_HIGH_CYC - 8'h01) begin
                            m_scl_q <= 1'b1;                // [R17]
                            m_cnt_q <= 8'h00;
                            m_bit_q <= m_bit_q + 4'h1;
                            m_state_q <= IBC_M_LOW;
                            if (m_bit_q != `IBC_ACK_BIT) begin
                                m_sh_q <= {m_sh_q[6:0], sda_s2}; // [R9]
                            end else begin
                                // Hold SCL low between bytes only [R23]
                                rs_valid_q <= 1'b1;
                                rs_nack_q  <= sda_s2;       // [R13]
                                m_after_nack_q <= sda_s2 & ~m_rd_q;
                                m_state_q  <= IBC_M_IDLE;   // [R7] [R8]
                            end
                        end
                    end
                end
                default: m_state_q <= IBC_M_IDLE;
            endcase
        end
    end

    // Slave side: follows every byte, answers only if not the owner
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_cnt_q  <= 4'h0;
            s_sh_q   <= 8'h00;
            s_tx_q   <= 8'h00;
            s_addr_q <= 1'b0;
            s_sel_q  <= 1'b0;
            s_rd_q   <= 1'b0;
            s_sda_q  <= 1'b0;
            s_go_q   <= 1'b0;
        end else if (start_det) begin
            // The SCL fall that follows a start carries no bit
            s_cnt_q  <= `IBC_PRE_BIT;                       // [R26]
            s_addr_q <= 1'b1;
            s_sel_q  <= 1'b0;
            s_sda_q  <= 1'b0;
        end else if (stop_det) begin
            s_addr_q <= 1'b0;
            s_sel_q  <= 1'b0;
            s_sda_q  <= 1'b0;                               // [R3]
        end else if (scl_rise && s_cnt_q != `IBC_ACK_BIT) begin
            s_sh_q <= {s_sh_q[6:0], sda_s2};                // [R9]
        end else if (scl_rise) begin
            s_go_q <= ~sda_s2;
        end else if (scl_fall && s_cnt_q == 4'h7) begin
            s_cnt_q <= `IBC_ACK_BIT;
            if (s_addr_q) begin
                // Unaddressed or receiving but full: stay released
                s_sel_q <= (s_sh_q[7:1] == own_addr) & ~m_own_q; // [R21]
                s_rd_q  <= s_sh_q[0];
                s_sda_q <= (s_sh_q[7:1] == own_addr) & ~m_own_q
                           & (s_sh_q[0] | fifo_ready);      // [R15]
                s_go_q  <= 1'b1;
            end else begin
                s_sda_q <= s_sel_q & ~s_rd_q & fifo_ready;  // [R12] [R15]
            end
        end else if (scl_fall && s_cnt_q == `IBC_ACK_BIT) begin
            s_cnt_q  <= 4'h0;
            s_addr_q <= 1'b0;
            s_tx_q   <= {slv_tx_data[6:0], 1'b0};
            s_sda_q  <= s_sel_q & s_rd_q & s_go_q & ~slv_tx_data[7];
            s_sel_q  <= s_sel_q & (~s_rd_q | s_go_q);       // [R13]
        end else if (scl_fall) begin
            s_cnt_q <= s_cnt_q + 4'h1;
            s_tx_q  <= {s_tx_q[6:0], 1'b0};
            s_sda_q <= s_sel_q & s_rd_q & s_go_q & ~s_tx_q[7]; // [R24]
        end
    end

    // Received bytes from either role enter the FIFO at the ack slot
    assign push_ok = (m_state_q == IBC_M_HIGH) && (m_act_q == IBC_ACT_BIT)
                     && m_rd_q && scl_s2 && (m_bit_q == 4'h7)
                     && (m_cnt_q == `IBC_HIGH_CYC - 8'h01);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_q      <= 1'b0;
            push_data_q <= 8'h00;
        end else begin
            push_q <= push_ok || (scl_fall && s_cnt_q == 4'h7
                      && !s_addr_q && s_sel_q && !s_rd_q && fifo_ready);
            push_data_q <= push_ok ? {m_sh_q[6:0], sda_s2} : s_sh_q;
        end
    end

    ibc_fifo #(
        .W (`IBC_FIFO_W),
        .D (`IBC_FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push_q),
        .in_ready  (fifo_ready),
        .in_data   (push_data_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // Pins only pull low or release; reads wait for FIFO room
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rdy_q    <= 1'b0;
        end else begin
            scl_oe_q <= m_scl_q & m_own_q;                  // [R25]
            sda_oe_q <= m_sda_q | s_sda_q;                  // [R25]
            rdy_q    <= (m_state_q == IBC_M_IDLE) && !accept
                        && !rs_valid_q && fifo_ready;
        end
    end
    assign scl_oe    = scl_oe_q;
    assign sda_oe    = sda_oe_q;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign cmd_ready = rdy_q;
    assign res_valid = rs_valid_q;
    assign res_nack  = rs_nack_q;
    assign res_lost  = rs_lost_q;
    assign res_err   = rs_err_q;
    assign bus_busy  = busy_q;
    assign slv_sel   = s_sel_q;

    start_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        start_det |=> busy_q) else $error("busy not set by start"); // [R4]
    stop_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        stop_det |=> busy_q [*3]) else $error("bus freed too early"); // [R4]
    free_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(m_own_q) |-> !$past(busy_q)) else $error("start on busy bus"); // [R18]
    arb_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        arb_lost |=> !m_sda_q && !m_own_q ##1 !sda_oe_q || s_sda_q)
        else $error("arbitration loss kept driving"); // [R19]
    stretch_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        (m_state_q == IBC_M_HIGH && !scl_s2 && m_cnt_q == 8'h00)
        |=> m_state_q == IBC_M_HIGH) else $error("stretch ignored"); // [R10]
    sync_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (m_state_q == IBC_M_HIGH && !scl_s2 && m_cnt_q != 8'h00)
        |=> m_state_q == IBC_M_LOW && m_cnt_q == 8'h00 ##1 scl_oe_q)
        else $error("low count not restarted"); // [R16]
    seq_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        start_det |=> s_cnt_q == `IBC_PRE_BIT && s_addr_q && !s_sda_q)
        else $error("start did not reset sequencing"); // [R26]
    slave_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_sda_q && !s_rd_q |-> s_cnt_q == `IBC_ACK_BIT)
        else $error("slave drove outside ack slot"); // [R3]
    full_nack_a: assert property (@(posedge clk) disable iff (!rst_n)
        (scl_fall && s_cnt_q == 4'h7 && !fifo_ready && !s_addr_q)
        |=> !s_sda_q) else $error("full receiver acked"); // [R15]
    data_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(m_sda_q) && m_state_q == IBC_M_LOW |-> m_scl_q)
        else $error("data changed with clock released"); // [R24]
endmodule // ibc_core

// [verification/ibc_peer.sv]
// Behavioural slave that shares the two-wire bus with the core
`timescale 1ns/1ns
module ibc_peer #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       stretch,
    output logic            scl_oe,
    output logic            sda_oe,
    output logic [7:0]      last
);
    logic [7:0] sh;
    int         n;
    logic       first;
    logic       sel;
    initial begin
        {scl_oe, sda_oe, sel, sh, last, first} = '0;
        n = 0;
    end
    always @(sda) if (scl === 1'b1) begin
        n = 0;
        first = !sda;
    end
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        n = n + 1;
    end
    // Lines are only ever pulled low or let go
    always @(negedge scl) begin
        sda_oe = 1'b0;
        if (n == 8) begin
            if (first) sel = (sh[7:1] == ADDR) && !sh[0];
            else if (sel) last = sh;
            sda_oe = sel;  // Held low across the high phase
            first = 1'b0;
        end else if (n == 9) n = 0;
    end
    // Longer than the master's own low time, so the wait really shows
    always @(negedge scl) if (stretch) begin
        scl_oe = 1'b1;
        #8000 scl_oe = 1'b0;
    end
endmodule  // ibc_peer

// [verification/ibc_core_tb_top.sv]
// Self-checking bench for the two-wire bus protocol core
`timescale 1ns/1ns
module ibc_core_tb_top;
    import ibc_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cmd_valid = 1'b0;
    logic       rx_ready = 1'b0;
    logic       stretch = 1'b0;
    logic       t_scl_oe = 1'b0;
    logic       t_sda_oe = 1'b0;
    ibc_cmd_t   cmd = IBC_CMD_START;
    logic [7:0] cmd_data = 8'h00;
    logic       cmd_ready, res_valid, res_nack, res_lost, res_err;
    logic       d_scl_oe, d_sda_oe, p_scl_oe, p_sda_oe, slv_sel, rx_valid;
    logic       bus_busy, r_nack, r_err, r_lost;
    logic [7:0] rx_data, last;
    int         errors = 0;
    int         n_tests = 0;
    wire        scl = !(d_scl_oe | p_scl_oe | t_scl_oe);
    wire        sda = !(d_sda_oe | p_sda_oe | t_sda_oe);
    always #50 clk = !clk;
    ibc_core ibc_core_inst (.clk(clk), .rst_n(rst_n), .scl_i(scl),
        .scl_o(), .scl_oe(d_scl_oe), .sda_i(sda), .sda_o(),
        .sda_oe(d_sda_oe), .own_addr(7'h11), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .cmd_data(cmd_data),
        .cmd_nack(1'b0), .res_valid(res_valid), .res_nack(res_nack),
        .res_lost(res_lost), .res_err(res_err), .slv_tx_data(8'h00),
        .slv_sel(slv_sel), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .bus_busy(bus_busy));
    ibc_peer ibc_peer_inst (.scl(scl), .sda(sda), .stretch(stretch),
        .scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .last(last));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic print_verdict;
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_cmd(input ibc_cmd_t c, input logic [7:0] d);
        int i;
        cmd = c;
        cmd_data = d;
        cmd_valid = 1'b1;
        for (i = 0; !cmd_ready && i < 9000; i++) tick(1);
        tick(1);
        cmd_valid = 1'b0;
        for (; !res_valid && i < 9000; i++) tick(1);
        if (i >= 9000) begin
            errors++;
            print_verdict();
        end
        r_nack = res_nack;
        r_err = res_err;
        r_lost = res_lost;
    endtask
    // Bench as remote master, 800 ns per bit, data moved while SCL low
    task automatic m_byte(input logic [7:0] b, output logic a);
        for (int i = 8; i >= 0; i--) begin
            t_scl_oe = 1'b1;
            tick(1);
            t_sda_oe = (i > 0) ? !b[i-1] : 1'b0;
            tick(3);
            t_scl_oe = 1'b0;
            tick(3);
            a = sda;
            tick(1);
        end
    endtask
    task automatic master_wr;
        do_cmd(IBC_CMD_READ, 8'h00);
        chk(r_err, 1'b1, "read without bus");
        do_cmd(IBC_CMD_STOP, 8'h00);
        chk(r_err, 1'b1, "stop without owning bus");
        do_cmd(IBC_CMD_START, 8'h00);
        tick(2);
        chk(bus_busy, 1'b1, "busy after start");
        do_cmd(IBC_CMD_WRITE, 8'h54);
        chk(r_nack, 1'b0, "address ack");
        stretch = 1'b1;
        do_cmd(IBC_CMD_WRITE, 8'hA5);
        stretch = 1'b0;
        chk(r_nack, 1'b0, "ack under stretch");
        chk(last, 8'hA5, "byte at peer");
        do_cmd(IBC_CMD_START, 8'h00);
        chk(bus_busy, 1'b1, "busy kept");
        do_cmd(IBC_CMD_WRITE, 8'h56);
        chk(r_nack, 1'b1, "unowned address");
        do_cmd(IBC_CMD_WRITE, 8'h00);
        chk(r_err, 1'b1, "write after nack");
        do_cmd(IBC_CMD_STOP, 8'h00);
        tick(20);
        chk(bus_busy, 1'b1, "free too soon");
        tick(40);
        chk(bus_busy, 1'b0, "bus free");
        // Bench holds SDA low as a rival master while the core sends ones
        do_cmd(IBC_CMD_START, 8'h00);
        t_sda_oe = 1'b1;
        do_cmd(IBC_CMD_WRITE, 8'hFF);
        chk(r_lost, 1'b1, "arbitration lost");
        tick(2);
        chk(d_sda_oe, 1'b0, "data released");
        do_cmd(IBC_CMD_STOP, 8'h00);
        chk(r_err, 1'b1, "stop after loss");
        t_sda_oe = 1'b0;
        tick(60);
    endtask
    // Nine bytes into an 8-word buffer: the last one must be refused
    task automatic slave_fill;
        logic a;
        t_sda_oe = 1'b1;
        tick(4);
        m_byte(8'h22, a);
        chk(a, 1'b0, "own address ack");
        chk(slv_sel, 1'b1, "addressed as slave");
        chk(bus_busy, 1'b1, "start seen");
        for (int k = 0; k < 9; k++) begin
            m_byte(8'h30 + 8'(k), a);
            chk(a, k == 8, "ack while room");
        end
        t_scl_oe = 1'b1;
        tick(1);
        t_sda_oe = 1'b1;
        tick(3);
        t_scl_oe = 1'b0;
        tick(4);
        t_sda_oe = 1'b0;
        tick(2);
        rx_ready = 1'b1;
        for (int k = 0; k < 8; k++) begin
            chk(rx_data, 8'h30 + 8'(k), "buffered byte");
            tick(1);
        end
        rx_ready = 1'b0;
        chk(rx_valid, 1'b0, "buffer empty");
        tick(60);
        chk(bus_busy, 1'b0, "stop seen");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick(2);
        master_wr();
        slave_fill();
        print_verdict();
    end
endmodule  // ibc_core_tb_top
